// *** src/rfa_pkg.sv ***
// Package for the register field access bank: access kinds, map, reset values.
// Assumes one clock domain and a simple request/response command port.
package rfa_pkg;

  localparam int RFA_NREG = 8;
  localparam int RFA_DW = 32;
  localparam int RFA_IDXW = 3;

  // Field behaviour of a whole register
  typedef enum logic [7:0] {
    RFA_RW   = 8'h01,
    RFA_RO   = 8'h02,
    RFA_RC   = 8'h04,
    RFA_RWC  = 8'h08,
    RFA_RW1C = 8'h10,
    RFA_W1C  = 8'h20,
    RFA_RW1S = 8'h40,
    RFA_WO   = 8'h80
  } rfa_access_e;

  // Offsets relative to the module base address
  localparam logic [11:0] RFA_OFF_CTRL = 12'h000;
  localparam logic [11:0] RFA_OFF_STAT = 12'h004;
  localparam logic [11:0] RFA_OFF_RDCLR = 12'h008;
  localparam logic [11:0] RFA_OFF_WRCLR = 12'h00C;
  localparam logic [11:0] RFA_OFF_INTST = 12'h010;
  localparam logic [11:0] RFA_OFF_INTCL = 12'h014;
  localparam logic [11:0] RFA_OFF_SETEN = 12'h018;
  localparam logic [11:0] RFA_OFF_CMD = 12'h01C;
  localparam logic [11:0] RFA_OFF_LIMIT = 12'h020;
  localparam logic [11:0] RFA_WIN_MASK = 12'hFFF;

  // Bits 31:24 of every register are reserved
  localparam logic [31:0] RFA_RESV = 32'hFF00_0000;

  localparam rfa_access_e RFA_ACC [RFA_NREG] = '{
    RFA_RW, RFA_RO, RFA_RC, RFA_RWC, RFA_RW1C, RFA_W1C, RFA_RW1S, RFA_WO};

  // Nondeterministic fields are given zero
  localparam logic [31:0] RFA_RST [RFA_NREG] = '{
    32'h0000_0001, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } rfa_req_s;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [31:0] rdata;
  } rfa_rsp_s;

  typedef logic [RFA_NREG-1:0][RFA_DW-1:0] rfa_bank_t;

endpackage

// *** src/rfa_field_reg.sv ***
// One 32-bit register whose fields share one access kind.
// Assumes wr and rd are one-cycle strobes from the bank decoder.
`timescale 1ns/1ps
module rfa_field_reg #(
  parameter rfa_pkg::rfa_access_e ACC = rfa_pkg::RFA_RW,
  parameter logic [31:0] RST_VAL = 32'h0000_0000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Software access strobes
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] wdata,
  // Hardware side
  input wire logic [31:0] hw_set,
  input wire logic [31:0] hw_clr,
  input wire logic [31:0] hw_val,
  output logic [31:0] value
);
  import rfa_pkg::*;

  typedef struct packed {
    logic [31:0] value;
  } rfa_fld_s;

  rfa_fld_s st;
  rfa_fld_s next_st;
  logic [31:0] set_m;

  assign value = st.value;

  always_comb begin
    next_st = st;
    set_m = hw_set & ~RFA_RESV;
    unique case (ACC)
      RFA_RW: if (wr) next_st.value = wdata;
      RFA_RO: next_st.value = hw_val;
      RFA_RC: begin
        // Event in the read cycle survives the clear
        if (rd) next_st.value = 32'h0000_0000;
        next_st.value = next_st.value | set_m;
      end
      RFA_RWC: begin
        if (wr) next_st.value = 32'h0000_0000;
        next_st.value = next_st.value | set_m;
      end
      RFA_RW1C, RFA_W1C: begin
        if (wr) next_st.value = st.value & ~wdata;
        next_st.value = next_st.value | set_m;
      end
      RFA_RW1S: begin
        // Hardware clear first so a software set wins
        next_st.value = st.value & ~hw_clr;
        if (wr) next_st.value = next_st.value | wdata;
      end
      RFA_WO: if (wr) next_st.value = wdata;
    endcase
    next_st.value = next_st.value & ~RFA_RESV;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st.value <= RST_VAL & ~RFA_RESV;
    end else begin
      st <= next_st;
    end
  end

  rw_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ACC == RFA_RW) && wr |=> value == ($past(wdata) & ~RFA_RESV))
    else $error("read/write field did not take written data");

  rc_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ACC == RFA_RC) && rd && (hw_set == 32'h0000_0000) |=> value == 32'h0000_0000)
    else $error("clear-on-read field not cleared after read");

  rwc_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ACC == RFA_RWC) && wr && (hw_set == 32'h0000_0000) |=> value == 32'h0000_0000)
    else $error("clear-on-write register not cleared by write");

  w1c_bits_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ACC == RFA_RW1C) && wr |=>
      value == ((($past(value) & ~$past(wdata)) | $past(hw_set)) & ~RFA_RESV))
    else $error("write-one-to-clear touched the wrong bits");

  w1c_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ACC == RFA_W1C) && wr && (wdata == 32'h0000_0000) && (hw_set == 32'h0000_0000)
      |=> $stable(value))
    else $error("write of zeros changed a write-one-to-clear register");

  w1s_set_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ACC == RFA_RW1S) && wr |=>
      value == ((($past(value) & ~$past(hw_clr)) | $past(wdata)) & ~RFA_RESV))
    else $error("write-one-to-set result wrong");

  ro_track_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ACC == RFA_RO) && wr |=> value == ($past(hw_val) & ~RFA_RESV))
    else $error("read-only field followed software data");

  resv_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (value & RFA_RESV) == 32'h0000_0000)
    else $error("reserved bits not zero");

endmodule // rfa_field_reg

// *** src/rfa_reg_bank.sv ***
// Register bank showing every field access kind behind one command port.
// Assumes requests are synchronous to sys_clk and addresses are byte addresses.
`timescale 1ns/1ps
module rfa_reg_bank #(
  parameter logic [31:0] BASE_ADDR = 32'h4000_0000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Command port
  input wire rfa_pkg::rfa_req_s req,
  output rfa_pkg::rfa_rsp_s rsp,
  // Hardware side of the fields
  input wire rfa_pkg::rfa_bank_t hw_set,
  input wire rfa_pkg::rfa_bank_t hw_clr,
  input wire rfa_pkg::rfa_bank_t hw_val,
  output rfa_pkg::rfa_bank_t field_val
);
  import rfa_pkg::*;

  typedef struct packed {
    rfa_rsp_s rsp;
  } rfa_bank_s;

  rfa_bank_s st;
  rfa_bank_s next_st;
  logic [31:0] rel;
  logic hit;
  logic [RFA_IDXW-1:0] idx;
  logic [RFA_NREG-1:0] wr_sel;
  logic [RFA_NREG-1:0] rd_sel;
  logic [31:0] rd_mux;

  // Decode relative to the base; narrow window keeps the compare cheap
  always_comb begin
    rel = req.addr - BASE_ADDR;
    hit = req.valid && (rel[31:12] == 20'h00000) && (rel[1:0] == 2'h0)
      && (rel[11:0] < RFA_OFF_LIMIT);
    idx = rel[RFA_IDXW+1:2];
  end

  genvar g;
  generate
    for (g = 0; g < RFA_NREG; g++) begin : gen_reg
      assign wr_sel[g] = hit && req.write && (idx == RFA_IDXW'(g));
      assign rd_sel[g] = hit && !req.write && (idx == RFA_IDXW'(g));
      rfa_field_reg #(
        .ACC(RFA_ACC[g]),
        .RST_VAL(RFA_RST[g])
      ) u_reg (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .wr(wr_sel[g]),
        .rd(rd_sel[g]),
        .wdata(req.wdata),
        .hw_set(hw_set[g]),
        .hw_clr(hw_clr[g]),
        .hw_val(hw_val[g]),
        .value(field_val[g])
      );
    end
  endgenerate

  // Write-only kinds return zero so stale contents never leak
  always_comb begin
    rd_mux = 32'h0000_0000;
    if ((RFA_ACC[idx] != RFA_WO) && (RFA_ACC[idx] != RFA_W1C)) begin
      rd_mux = field_val[idx];
    end
  end

  always_comb begin
    next_st = st;
    next_st.rsp.valid = req.valid;
    next_st.rsp.hit = hit;
    next_st.rsp.rdata = 32'h0000_0000;
    if (hit && !req.write) begin
      next_st.rsp.rdata = rd_mux & ~RFA_RESV;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rsp = st.rsp;

  rc_return_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    req.valid && !req.write && (req.addr == BASE_ADDR + 32'(RFA_OFF_RDCLR))
      |=> rsp.valid && rsp.hit && (rsp.rdata == $past(field_val[2])))
    else $error("clear-on-read did not return the pre-clear value");

  wo_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    req.valid && !req.write && ((req.addr == BASE_ADDR + 32'(RFA_OFF_CMD))
      || (req.addr == BASE_ADDR + 32'(RFA_OFF_INTCL)))
      |=> rsp.hit && (rsp.rdata == 32'h0000_0000))
    else $error("write-only register leaked contents");

  unmapped_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    req.valid && ((req.addr - BASE_ADDR) >= 32'(RFA_OFF_LIMIT))
      |=> rsp.valid && !rsp.hit && (rsp.rdata == 32'h0000_0000))
    else $error("access outside the module window was decoded");

  rw_readback_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    req.valid && req.write && (req.addr == BASE_ADDR + 32'(RFA_OFF_CTRL))
      ##1 req.valid && !req.write && (req.addr == BASE_ADDR + 32'(RFA_OFF_CTRL))
      |=> rsp.rdata == ($past(req.wdata, 2) & ~RFA_RESV))
    else $error("read/write register did not read back the written value");

  answer_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    req.valid |=> rsp.valid)
    else $error("request without an answer");

  idle_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !req.valid |=> !rsp.valid && !rsp.hit && (rsp.rdata == 32'h0000_0000))
    else $error("answer without a request");

  hit_decode_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    req.valid && (req.addr[1:0] == BASE_ADDR[1:0])
      && ((req.addr - BASE_ADDR) < 32'(RFA_OFF_LIMIT))
      |=> rsp.valid && rsp.hit)
    else $error("aligned access inside the window not decoded");

  // Misaligned addresses must not alias onto the register below them
  miss_still_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    req.valid && ((req.addr[1:0] != BASE_ADDR[1:0])
      || ((req.addr - BASE_ADDR) >= 32'(RFA_OFF_LIMIT)))
      |=> $stable(field_val[0]))
    else $error("unmapped access changed a register");

  rc_after_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    req.valid && !req.write && (req.addr == BASE_ADDR + 32'(RFA_OFF_RDCLR))
      |=> field_val[2] == ($past(hw_set[2]) & ~RFA_RESV))
    else $error("clear-on-read register kept its value after a read");

  rwc_any_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    req.valid && req.write && (req.addr == BASE_ADDR + 32'(RFA_OFF_WRCLR))
      |=> field_val[3] == ($past(hw_set[3]) & ~RFA_RESV))
    else $error("write to clear-on-write register left bits set");

  w1c_wo_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    req.valid && req.write && (req.addr == BASE_ADDR + 32'(RFA_OFF_INTCL))
      |=> field_val[5] == ((($past(field_val[5]) & ~$past(req.wdata)) | $past(hw_set[5]))
        & ~RFA_RESV))
    else $error("write-only clear register touched the wrong bits");

  w1s_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    req.valid && req.write && (req.addr == BASE_ADDR + 32'(RFA_OFF_SETEN))
      && (hw_clr[6] == 32'h0000_0000)
      |=> (field_val[6] & $past(field_val[6])) == $past(field_val[6]))
    else $error("write-one-to-set register lost a set bit");

  wo_take_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    req.valid && req.write && (req.addr == BASE_ADDR + 32'(RFA_OFF_CMD))
      |=> field_val[7] == ($past(req.wdata) & ~RFA_RESV))
    else $error("write-only register did not take written data");

  ro_ignore_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    req.valid && req.write && (req.addr == BASE_ADDR + 32'(RFA_OFF_STAT))
      |=> field_val[1] == ($past(hw_val[1]) & ~RFA_RESV))
    else $error("read-only register followed software data");

endmodule // rfa_reg_bank

// *** tb/rfa_sw_model.sv ***
// Software master model of the command port.
// Assumes one answer, registered on the taking edge and sampled 1 ns after it.
`timescale 1ns/1ps
module rfa_sw_model (
  // Clock
  input wire logic sys_clk,
  // Command port
  output rfa_pkg::rfa_req_s req,
  input wire rfa_pkg::rfa_rsp_s rsp
);
  import rfa_pkg::*;
  initial req = '0;
  task automatic access(input logic w, input logic [31:0] a, input logic [31:0] d,
      output rfa_rsp_s r);
    @(posedge sys_clk) #1;
    req <= '{1'b1, w, a, d};
    @(posedge sys_clk) #1;
    r = rsp;
    // Released lines show the inverse, never a stale copy
    req <= '{1'b0, ~w, ~a, ~d};
  endtask
  // Write then read back to back; valid stays high between the two
  task automatic wr_rd(input logic [31:0] a, input logic [31:0] d, output rfa_rsp_s r);
    @(posedge sys_clk) #1;
    req <= '{1'b1, 1'b1, a, d};
    @(posedge sys_clk) #1;
    req <= '{1'b1, 1'b0, a, ~d};
    @(posedge sys_clk) #1;
    r = rsp;
    req <= '{1'b0, 1'b1, ~a, d};
  endtask
  // Reserved bits keep what was read
  task automatic rmw(input logic [31:0] a, input logic [31:0] clr, output rfa_rsp_s r);
    logic [31:0] nv;
    access(1'b0, a, 32'h0000_0000, r);
    nv = (r.rdata & RFA_RESV) | (r.rdata & ~clr & ~RFA_RESV);
    access(1'b1, a, nv, r);
  endtask
endmodule // rfa_sw_model

// *** tb/test_register_field_access_types.sv ***
// Bench for the field access bank: one task per two field kinds, plus decode-miss and reset tasks.
// Assumes the software model on the command port.
`timescale 1ns/1ps
module test_register_field_access_types;
  import rfa_pkg::*;
  localparam logic [31:0] BASE = 32'h4000_0000;
  logic sys_clk;
  logic rst_b;
  rfa_req_s req;
  rfa_rsp_s rsp;
  rfa_rsp_s r;
  rfa_bank_t hw_set;
  rfa_bank_t hw_clr;
  rfa_bank_t hw_val;
  rfa_bank_t field_val;
  int fails;
  int checks_done;
  rfa_reg_bank #(.BASE_ADDR(BASE)) dut (.sys_clk(sys_clk), .rst_b(rst_b), .req(req),
    .rsp(rsp), .hw_set(hw_set), .hw_clr(hw_clr), .hw_val(hw_val), .field_val(field_val));
  rfa_sw_model sw (.sys_clk(sys_clk), .req(req), .rsp(rsp));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic acc(input logic w, input logic [11:0] off, input logic [31:0] d);
    sw.access(w, BASE + {20'h0_0000, off}, d, r);
    check({31'h0, r.valid & r.hit}, 32'h1);
  endtask
  task automatic ev(input int i, input logic [31:0] v);
    @(posedge sys_clk) #1;
    hw_set[i] = v;
    @(posedge sys_clk) #1;
    hw_set[i] = '0;
  endtask
  task automatic t_rw_ro();
    sw.wr_rd(BASE + {20'h0_0000, RFA_OFF_CTRL}, 32'h5A00_A55A, r);
    check(r.rdata, 32'h0000_A55A);
    acc(1'b1, RFA_OFF_CTRL, 32'hA5A5_5A5A);
    acc(1'b0, RFA_OFF_CTRL, '0);
    check(r.rdata, 32'h00A5_5A5A);
    hw_val[1] = 32'h0012_3456;
    acc(1'b1, RFA_OFF_STAT, 32'h00FF_FFFF);
    acc(1'b0, RFA_OFF_STAT, '0);
    check(r.rdata, 32'h0012_3456);
    acc(1'b1, RFA_OFF_STAT, RFA_RST[1]);
  endtask
  task automatic t_clears();
    ev(2, 32'h0000_00F0);
    acc(1'b0, RFA_OFF_RDCLR, '0);
    check(r.rdata, 32'h0000_00F0);
    acc(1'b0, RFA_OFF_RDCLR, '0);
    check(r.rdata, '0);
    ev(3, 32'h0000_0F0F);
    acc(1'b1, RFA_OFF_WRCLR, 32'h0000_0001);
    check(field_val[3], '0);
  endtask
  task automatic t_w1c();
    ev(4, 32'h0000_0033);
    acc(1'b1, RFA_OFF_INTST, 32'h0000_0011);
    check(field_val[4], 32'h0000_0022);
    sw.rmw(BASE + {20'h0_0000, RFA_OFF_INTST}, 32'h0000_0000, r);
    check(field_val[4], '0);
    ev(5, 32'h0000_000C);
    acc(1'b1, RFA_OFF_INTCL, 32'h0000_0004);
    check(field_val[5], 32'h0000_0008);
    acc(1'b1, RFA_OFF_INTCL, '0);
    check(field_val[5], 32'h0000_0008);
    acc(1'b0, RFA_OFF_INTCL, '0);
    check(r.rdata, '0);
  endtask
  task automatic t_set_wo();
    acc(1'b1, RFA_OFF_SETEN, 32'h0000_0003);
    acc(1'b1, RFA_OFF_SETEN, '0);
    check(field_val[6], 32'h0000_0003);
    acc(1'b1, RFA_OFF_CMD, 32'h00C0_FFEE);
    check(field_val[7], 32'h00C0_FFEE);
    acc(1'b0, RFA_OFF_CMD, '0);
    check(r.rdata, '0);
  endtask
  task automatic t_miss();
    logic [31:0] offs [3] = '{32'h20, 32'h2, 32'hFFFF_FFFC};
    foreach (offs[k]) begin
      sw.access(1'b1, BASE + offs[k], 32'hFFFF_FFFF, r);
      check({31'h0, r.hit}, '0);
    end
    check(field_val[0], 32'h00A5_5A5A);
  endtask
  // Mid-run reset must restore every register, not only the power-up one
  task automatic t_reset();
    @(posedge sys_clk) #1;
    rst_b = 1'b0;
    @(posedge sys_clk) #1;
    for (int i = 0; i < RFA_NREG; i++) begin
      check(field_val[i], RFA_RST[i]);
    end
    check({31'h0, rsp.valid | rsp.hit}, '0);
    check(rsp.rdata, '0);
    rst_b = 1'b1;
    acc(1'b0, RFA_OFF_CTRL, '0);
    check(r.rdata, RFA_RST[0]);
  endtask
  initial begin
    repeat (3000) @(posedge sys_clk);
    fails++;
    end_of_test();
  end
  initial begin
    rst_b = 1'b0;
    hw_set = '0;
    hw_clr = '0;
    hw_val = '0;
    fails = 0;
    checks_done = 0;
    repeat (10) @(posedge sys_clk);
    #1;
    for (int i = 0; i < RFA_NREG; i++) begin
      check(field_val[i], RFA_RST[i]);
    end
    rst_b = 1'b1;
    t_rw_ro();
    t_clears();
    t_w1c();
    t_set_wo();
    t_miss();
    t_reset();
    end_of_test();
  end
endmodule // test_register_field_access_types
